// ==== hw/hw_stack_pkg.sv ====
// Constants shared by the return stack and its storage.
// Assumes a single 10 MHz core clock and synchronous active-high reset.
package hw_stack_pkg;
  localparam int Depth = 4;
  localparam int EntryWidth = 12;
  localparam int AccWidth = 32;
  localparam logic [11:0] EntryReset = 12'h000;
  localparam logic [31:0] AccReset = 32'h0000_0000;
  localparam logic [11:0] PcReset = 12'h000;
  localparam logic [1:0] PopRunReset = 2'h0;
endpackage

// ==== hw/stack_storage.sv ====
// Four-word shift store for the return stack.
// Assumes push and pop never arrive together; push wins if they do.
`timescale 1ns/1ns
`default_nettype none
module stack_storage (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Shift controls
  input wire logic push,
  input wire logic pop,
  input wire logic [11:0] pushData,
  // Entries, index 0 is the top
  output logic [11:0] entry0,
  output logic [11:0] entry1,
  output logic [11:0] entry2,
  output logic [11:0] entry3
);
  always_ff @(posedge clock) begin
    if (reset) begin
      entry0 <= hw_stack_pkg::EntryReset;
      entry1 <= hw_stack_pkg::EntryReset;
      entry2 <= hw_stack_pkg::EntryReset;
      entry3 <= hw_stack_pkg::EntryReset;
    end else if (push) begin
      // The old bottom word falls off silently.
      entry3 <= entry2;
      entry2 <= entry1;
      entry1 <= entry0;
      entry0 <= pushData;
    end else if (pop) begin
      // Bottom word stays, so it duplicates upward.
      entry0 <= entry1;
      entry1 <= entry2;
      entry2 <= entry3;
    end
  end
endmodule
`default_nettype wire

// ==== hw/hardware_return_stack.sv ====
// Assumes the core sequencer raises at most one push strobe per cycle.
`timescale 1ns/1ns
`default_nettype none
module hardware_return_stack (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Push sources, one-cycle strobes
  input wire logic pushOp,
  input wire logic call_from_accumulator,
  input wire logic callOp,
  input wire logic table_read_op,
  input wire logic table_write_op,
  input wire logic interruptEntry,
  input wire logic [11:0] pushValue,
  // Pop sources, one-cycle strobes
  input wire logic popOp,
  input wire logic returnOp,
  // Results
  output logic [31:0] accLoad,
  output logic accLoadValid,
  output logic [11:0] pcLoad,
  output logic pcLoadValid,
  output logic [11:0] stack_top_entry,
  output logic [11:0] stackBottom
);
  logic anyPush;
  logic anyPop;
  logic popTake;
  logic returnTake;
  logic [1:0] popRun;
  logic [11:0] e0;
  logic [11:0] e1;
  logic [11:0] e2;
  logic [11:0] e3;

  // A pop-side strobe is only taken when no push shares its cycle, so a push always wins.
  function automatic logic popTaken(input logic strobeIn, input logic pushIn);
    popTaken = strobeIn & ~pushIn;
  endfunction

  // The accumulator sees a stack word with its upper twenty bits cleared.
  function automatic logic [31:0] zeroExtend(input logic [11:0] word);
    zeroExtend = {20'h00000, word};
  endfunction

  // Every push source shares one shift path.
  assign anyPush = pushOp | call_from_accumulator | callOp | table_read_op | table_write_op | interruptEntry;
  // Pop and return share the same pop-up shift.
  assign anyPop = popTaken(popOp | returnOp, anyPush);
  assign popTake = popTaken(popOp, anyPush);
  assign returnTake = popTaken(returnOp, anyPush);

  // Four fixed entries held in shift storage.
  stack_storage store (
    .clock(clock),
    .reset(reset),
    .push(anyPush),
    .pop(anyPop),
    .pushData(pushValue),
    .entry0(e0),
    .entry1(e1),
    .entry2(e2),
    .entry3(e3)
  );

  always_ff @(posedge clock) begin
    if (reset) begin
      accLoad <= hw_stack_pkg::AccReset;
      accLoadValid <= 1'b0;
    end else begin
      accLoadValid <= popTake;
      if (popTake) begin
        accLoad <= zeroExtend(e0);
      end
    end
  end

  // The top is sampled before the shift lands, so the old top returns.
  always_ff @(posedge clock) begin
    if (reset) begin
      pcLoad <= hw_stack_pkg::PcReset;
      pcLoadValid <= 1'b0;
    end else begin
      pcLoadValid <= returnTake;
      if (returnTake) begin
        pcLoad <= e0;
      end
    end
  end

  // Mirrors of the storage, registered so outputs come from flip-flops.
  always_ff @(posedge clock) begin
    if (reset) begin
      stack_top_entry <= hw_stack_pkg::EntryReset;
      stackBottom <= hw_stack_pkg::EntryReset;
    end else if (anyPush) begin
      stack_top_entry <= pushValue;
      stackBottom <= e2;
    end else if (anyPop) begin
      stack_top_entry <= e1;
      stackBottom <= e3;
    end
  end

  // Pops since the last push, saturating; pops need not be back to back to converge.
  always_ff @(posedge clock) begin
    if (reset) begin
      popRun <= hw_stack_pkg::PopRunReset;
    end else if (anyPush) begin
      popRun <= hw_stack_pkg::PopRunReset;
    end else if (anyPop && popRun != 2'(hw_stack_pkg::Depth - 1)) begin
      popRun <= popRun + 2'h1;
    end
  end

  // Assertions.
  a_push_top_load: assert property (
    @(posedge clock) disable iff (reset)
    anyPush |=> e0 == $past(pushValue))
    else $error("push did not load top");

  a_push_drops_bottom: assert property (
    @(posedge clock) disable iff (reset)
    anyPush |=> e3 == $past(e2) && e1 == $past(e0))
    else $error("push shift wrong");

  a_pop_acc_value: assert property (
    @(posedge clock) disable iff (reset)
    (popOp && !anyPush) |=> accLoadValid && accLoad == {20'h00000, $past(e0)})
    else $error("pop value wrong");

  a_pop_bottom_dup: assert property (
    @(posedge clock) disable iff (reset)
    anyPop |=> e3 == e2 && e0 == $past(e1))
    else $error("pop shift wrong");

  a_pops_converge: assert property (
    @(posedge clock) disable iff (reset)
    (anyPop && !anyPush) [*3] |=> e0 == e3 && e1 == e3 && e2 == e3)
    else $error("entries not equal");

  a_ret_pc_load: assert property (
    @(posedge clock) disable iff (reset)
    (returnOp && !anyPush) |=> pcLoadValid && pcLoad == $past(e0))
    else $error("return pc wrong");

  a_call_pushes: assert property (
    @(posedge clock) disable iff (reset)
    (callOp || interruptEntry || table_read_op) |=> e0 == $past(pushValue) && e2 == $past(e1))
    else $error("call push wrong");

  a_top_mirror: assert property (
    @(posedge clock) disable iff (reset)
    (anyPush || anyPop) |=> stack_top_entry == e0 && stackBottom == e3)
    else $error("mirror wrong");

  a_mirror_tracks: assert property (
    @(posedge clock) disable iff (reset)
    stack_top_entry == e0 && stackBottom == e3)
    else $error("mirror drifted");

  a_idle_holds: assert property (
    @(posedge clock) disable iff (reset)
    !anyPush && !anyPop |=> $stable(e0) && $stable(e1) && $stable(e2) && $stable(e3))
    else $error("idle stack moved");

  a_push_second: assert property (
    @(posedge clock) disable iff (reset)
    anyPush |=> e2 == $past(e1))
    else $error("push middle shift wrong");

  a_push_wins: assert property (
    @(posedge clock) disable iff (reset)
    anyPush && (popOp || returnOp) |=> e0 == $past(pushValue) && !accLoadValid && !pcLoadValid)
    else $error("pop taken beside push");

  a_table_pushes: assert property (
    @(posedge clock) disable iff (reset)
    (table_write_op || call_from_accumulator || pushOp) |=> e0 == $past(pushValue) && e3 == $past(e2))
    else $error("table push wrong");

  a_overflow_silent: assert property (
    @(posedge clock) disable iff (reset)
    anyPush |=> !accLoadValid && !pcLoadValid)
    else $error("push raised a pulse");

  a_push_mirror: assert property (
    @(posedge clock) disable iff (reset)
    anyPush |=> stack_top_entry == $past(pushValue) && stackBottom == $past(e2))
    else $error("push mirror wrong");

  a_acc_upper_zero: assert property (
    @(posedge clock) disable iff (reset)
    accLoad[31:12] == 20'h00000)
    else $error("accumulator upper bits set");

  a_acc_holds: assert property (
    @(posedge clock) disable iff (reset)
    !popTake |=> $stable(accLoad))
    else $error("accumulator changed without pop");

  a_acc_pulse_only: assert property (
    @(posedge clock) disable iff (reset)
    !popTake |=> !accLoadValid)
    else $error("stray accumulator pulse");

  a_pop_bottom_kept: assert property (
    @(posedge clock) disable iff (reset)
    anyPop |=> e3 == $past(e3) && e1 == $past(e2))
    else $error("pop moved bottom");

  a_pop_mirror: assert property (
    @(posedge clock) disable iff (reset)
    anyPop |=> stack_top_entry == $past(e1))
    else $error("pop mirror wrong");

  a_return_shifts: assert property (
    @(posedge clock) disable iff (reset)
    returnTake |=> e0 == $past(e1) && e2 == $past(e3))
    else $error("return shift wrong");

  a_pops_agree: assert property (
    @(posedge clock) disable iff (reset)
    popRun == 2'(hw_stack_pkg::Depth - 1) |-> e0 == e3 && e1 == e3 && e2 == e3)
    else $error("entries differ after pops");

  a_pop_return_pair: assert property (
    @(posedge clock) disable iff (reset)
    popTake && returnTake |=> accLoadValid && pcLoadValid && accLoad[11:0] == pcLoad)
    else $error("paired pop and return differ");

  a_pc_holds: assert property (
    @(posedge clock) disable iff (reset)
    !returnTake |=> $stable(pcLoad))
    else $error("pc changed without return");

  a_pc_pulse_only: assert property (
    @(posedge clock) disable iff (reset)
    !returnTake |=> !pcLoadValid)
    else $error("stray pc pulse");

  a_pc_from_top: assert property (
    @(posedge clock) disable iff (reset)
    returnTake |=> pcLoad == $past(stack_top_entry))
    else $error("pc not old top");
endmodule
`default_nettype wire

// ==== verification/core_sequencer_model.sv ====
// Stand-in for the core sequencer; issue raises one operation strobe, burst can raise several at once.
// Assumes the stack samples its inputs on the rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module core_sequencer_model (
  // Clock
  input wire logic clock,
  // Strobes: push, call from accumulator, call, table read, table write, interrupt, pop, return
  output logic [7:0] strobe,
  output logic [11:0] value
);
  initial begin
    strobe = 8'h00;
    value = 12'h000;
  end
  // Most instructions raise one strobe for one cycle.
  task automatic issue(input int k, input logic [11:0] v);
    @(negedge clock);
    strobe = 8'h01 << k;
    value = v;
    @(negedge clock);
    strobe = 8'h00;
    value = ~v;
  endtask
  // Holds a strobe pattern for n rising edges; several bits stand for the rare mixed cycles.
  task automatic burst(input logic [7:0] mask, input logic [11:0] v, input int n);
    @(negedge clock);
    strobe = mask;
    value = v;
    repeat (n) @(negedge clock);
    strobe = 8'h00;
    value = ~v;
  endtask
endmodule
`default_nettype wire

// ==== verification/hardware_return_stack_tb.sv ====
// Bench for the return stack: pushes from every source, overflow, pops and a return.
// Assumes the core model drives every strobe on the falling edge.
`timescale 1ns/1ns
`default_nettype none
module hardware_return_stack_tb;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] strobe;
  logic [11:0] value, pcLoad, stack_top_entry, stackBottom;
  logic [31:0] accLoad;
  logic accLoadValid, pcLoadValid;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #50 clock = ~clock;
  core_sequencer_model core_sequencer_model_inst (.clock(clock), .strobe(strobe), .value(value));
  hardware_return_stack hardware_return_stack_inst (.clock(clock), .reset(reset), .pushOp(strobe[0]),
    .call_from_accumulator(strobe[1]), .callOp(strobe[2]), .table_read_op(strobe[3]),
    .table_write_op(strobe[4]), .interruptEntry(strobe[5]), .pushValue(value), .popOp(strobe[6]),
    .returnOp(strobe[7]), .accLoad(accLoad), .accLoadValid(accLoadValid), .pcLoad(pcLoad),
    .pcLoadValid(pcLoadValid), .stack_top_entry(stack_top_entry), .stackBottom(stackBottom));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // The whole run needs about fifty-five cycles, so two hundred means a hang.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 200) begin
      $display("mismatch %0t timeout", $time);
      err_count = err_count + 1;
      conclude();
    end
  end
  task automatic test_push();
    for (int k = 0; k < 6; k++) begin
      core_sequencer_model_inst.issue(k, 12'h101 + 12'(k));
      chk({20'h0, stack_top_entry}, {20'h0, 12'h101 + 12'(k)});
    end
    chk({20'h0, stackBottom}, 32'h0000_0103);
    $display("push test done");
  endtask
  task automatic test_pop();
    core_sequencer_model_inst.issue(6, 12'h000);
    chk(accLoad, 32'h0000_0106);
    chk({31'h0, accLoadValid}, 32'h0000_0001);
    chk({8'h0, stack_top_entry, stackBottom}, 32'h0010_5103);
    core_sequencer_model_inst.issue(7, 12'h000);
    chk({19'h0, pcLoadValid, pcLoad}, 32'h0000_1105);
    chk({20'h0, stack_top_entry}, 32'h0000_0104);
    core_sequencer_model_inst.issue(6, 12'h000);
    core_sequencer_model_inst.issue(6, 12'h000);
    chk(accLoad, 32'h0000_0103);
    chk({8'h0, stack_top_entry, stackBottom}, 32'h0010_3103);
    $display("pop test done");
  endtask
  task automatic test_combo();
    for (int k = 0; k < 4; k++) begin
      core_sequencer_model_inst.issue(0, 12'h201 + 12'(k));
    end
    core_sequencer_model_inst.burst(8'h41, 12'h2AA, 1);
    chk({accLoadValid, pcLoadValid, 6'h0, stack_top_entry, stackBottom}, {8'h00, 12'h2AA, 12'h202});
    core_sequencer_model_inst.burst(8'hC0, 12'h000, 1);
    chk({pcLoadValid, 7'h0, pcLoad, accLoad[11:0]}, {8'h80, 12'h2AA, 12'h2AA});
    chk({accLoadValid, 7'h0, stack_top_entry, stackBottom}, {8'h80, 12'h204, 12'h202});
    core_sequencer_model_inst.burst(8'h40, 12'h000, 3);
    chk(accLoad, 32'h0000_0202);
    chk({8'h0, stack_top_entry, stackBottom}, 32'h0020_2202);
    $display("combo test done");
  endtask
  task automatic test_reset();
    reset = 1'b1;
    repeat (2) @(negedge clock);
    chk({accLoadValid, pcLoadValid, 18'h0, pcLoad}, 32'h0000_0000);
    chk(accLoad, 32'h0000_0000);
    chk({8'h0, stack_top_entry, stackBottom}, 32'h0000_0000);
    reset = 1'b0;
    $display("reset test done");
  endtask
  initial begin
    repeat (16) @(negedge clock);
    chk({8'h0, stack_top_entry, stackBottom}, 32'h0000_0000);
    reset = 1'b0;
    test_push();
    test_pop();
    test_combo();
    test_reset();
    conclude();
  end
endmodule
`default_nettype wire
